// [card_seq_pkg.sv]
// Constants, encodings and the register map of the card interface sequencer.
// Assumes a 40 MHz system clock; every count below is derived from it.
package card_seq_pkg;

  // System clock rate
  localparam int CLK_HZ             = 40000000;

  // Clock stop delay during power-down, in ns, and its cycle count (least time, rounded up)
  localparam int DEACT_CLK_DELAY_NS = 12000;
  localparam int DEACT_CLK_CYCLES   = (DEACT_CLK_DELAY_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // Spacing of the power-up steps, in ns, and its cycle count
  localparam int ACT_STEP_NS        = 12000;
  localparam int ACT_STEP_CYCLES    = (ACT_STEP_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // Insertion debounce, in ms, and its cycle count
  localparam int DEBOUNCE_MS        = 8;
  localparam int DEBOUNCE_CYCLES    = DEBOUNCE_MS * (CLK_HZ / 1000);

  // Widths
  localparam int SEQ_CNT_W          = 9;
  localparam int DB_CNT_W           = 19;
  localparam int ADDR_W             = 4;
  localparam int DATA_W             = 8;
  localparam int EV_W               = 5;

  // Divider select codes {ratio_sel_hi, ratio_sel_lo}
  localparam logic [1:0] RATIO_DIV8 = 2'h0;
  localparam logic [1:0] RATIO_DIV4 = 2'h1;
  localparam logic [1:0] RATIO_DIV1 = 2'h2;
  localparam logic [1:0] RATIO_DIV2 = 2'h3;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MASK    = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STATE   = 4'hC;

  // Field positions and reset values
  localparam int CTRL_CLK_RUN_BIT   = 0;
  localparam logic CTRL_CLK_RUN_RST = 1'b1;
  localparam int EV_INSERT          = 0;
  localparam int EV_REMOVE          = 1;
  localparam int EV_FAULT           = 2;
  localparam int EV_HOST_LOW        = 3;
  localparam int EV_DEACT_DONE      = 4;
  localparam logic [EV_W-1:0] MASK_RST = 5'h00;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE         = 3'h0,
    ST_ACT_SUPPLY   = 3'h1,
    ST_ACT_LINES    = 3'h2,
    ST_ACTIVE       = 3'h3,
    ST_DEACT_RESET  = 3'h4,
    ST_DEACT_CLOCK  = 3'h5,
    ST_DEACT_LINES  = 3'h6,
    ST_DEACT_SUPPLY = 3'h7
  } seq_state_t;

endpackage

// [card_interface_sequencer.sv]
// Card interface sequencer: clock divider, power-up/down sequencer, presence debounce,
// event status with mask and a small register port.
// Assumes all inputs, the host clock included, are synchronous to SYS_CLK.
// Notes on behaviour
// - Card clock is host clock divided by 8, 4, 1 or 2 by select pins.
// - Ratios 2, 4, 8 give a 50 percent duty card clock.
// - Card clock reaches the card only after power-up, then host gates it.
// - Power-down first forces card reset low.
// - Card clock goes low 12 us after card reset went low.
// - After the clock step, data and both aux lines are pulled low.
// - Card supply switches off last, after the lines are low.
// - Presence output low when no card seen, for both switch polarities.
// - Presence output high when a card is present and no fault is held.
// - Insertion debounced 8 ms before presence output rises.
// - Removal starts power-down at once and drops presence without debounce.
// - Host supply undervoltage starts power-down.
// - Pin current limit trips give no indication to the host.
`timescale 1ns/100ps
`default_nettype none
module card_interface_sequencer
  import card_seq_pkg::*;
#(
  parameter int DEBOUNCE_CYC = DEBOUNCE_CYCLES
) (
  // Clock, reset, enable
  input  wire logic              SYS_CLK,
  input  wire logic              SYS_RST,
  input  wire logic              CLK_EN,
  // Host pins
  input  wire logic              HOST_CLOCK_IN,
  input  wire logic              RATIO_SEL_HI,
  input  wire logic              RATIO_SEL_LO,
  input  wire logic              SESSION_CMD_N,
  input  wire logic              HOST_RESET_IN,
  output logic                   PRESENCE_OUT,
  // Card detect and fault sensors
  input  wire logic              CARD_DETECT_RAW,
  input  wire logic              DETECT_NC,
  input  wire logic              HOST_SUPPLY_LOW_DETECT,
  input  wire logic              SUPPLY_OVERLOAD,
  input  wire logic              SUPPLY_OUT_OF_RANGE,
  input  wire logic              REGULATOR_UV,
  input  wire logic              OVERHEAT,
  input  wire logic              PIN_CURRENT_LIMIT,
  // Card contacts
  output logic                   CARD_RESET_OUT,
  output logic                   CARD_CLOCK_OUT,
  output logic                   CARD_SUPPLY_OUT,
  output logic                   CARD_DATA_LINE_O,
  output logic                   CARD_DATA_LINE_OE,
  output logic                   CARD_AUX_LINE_A_O,
  output logic                   CARD_AUX_LINE_A_OE,
  output logic                   CARD_AUX_LINE_B_O,
  output logic                   CARD_AUX_LINE_B_OE,
  // Register port
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [DATA_W-1:0] REG_RDATA,
  output logic                   IRQ
);

  seq_state_t            state_reg;
  seq_state_t            state_next;
  logic [SEQ_CNT_W-1:0]  seq_cnt_reg;
  logic [DB_CNT_W-1:0]   db_cnt_reg;
  logic                  present_reg;
  logic                  fault_hold_reg;
  logic                  cmd_prev_reg;
  logic                  hclk_prev_reg;
  logic [1:0]            div_cnt_reg;
  logic                  div_clk_reg;
  logic                  clk_live_reg;
  logic                  clk_run_reg;
  logic [EV_W-1:0]       status_reg;
  logic [EV_W-1:0]       mask_reg;
  logic                  reset_out_reg;
  logic                  clock_out_reg;
  logic                  supply_reg;
  logic                  lines_low_reg;
  logic [DATA_W-1:0]     rdata_reg;
  logic [1:0]            ratio;
  logic [1:0]            half_len;
  logic                  hclk_rise;
  logic                  card_seen;
  logic                  fault_any;
  logic                  abort;
  logic                  session_up;
  logic [EV_W-1:0]       events;

  ////////////////////////////////////////////////////////////////////////////
  // Clock divider

  // Toggle after half_len+1 host rising edges
  assign ratio     = {RATIO_SEL_HI, RATIO_SEL_LO};
  assign hclk_rise = HOST_CLOCK_IN & ~hclk_prev_reg;
  always_comb begin
    case (ratio)
      RATIO_DIV8: half_len = 2'h3;
      RATIO_DIV4: half_len = 2'h1;
      default:    half_len = 2'h0;
    endcase
  end

  // Final flip-flop toggles on whole half periods, so duty stays even
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      hclk_prev_reg <= 1'b0;
      div_cnt_reg   <= 2'h0;
      div_clk_reg   <= 1'b0;
    end else if (CLK_EN) begin
      hclk_prev_reg <= HOST_CLOCK_IN;
      if (ratio == RATIO_DIV1) begin
        div_cnt_reg <= 2'h0;
        div_clk_reg <= HOST_CLOCK_IN;
      end else if (hclk_rise) begin
        if (div_cnt_reg >= half_len) begin
          div_cnt_reg <= 2'h0;
          div_clk_reg <= ~div_clk_reg;
        end else begin
          div_cnt_reg <= div_cnt_reg + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Presence debounce and faults

  // Polarity input folds normally-open and normally-closed switches together
  assign card_seen = CARD_DETECT_RAW ^ DETECT_NC;
  // Current limit stays local to the pin drivers and is never reported
  assign fault_any = SUPPLY_OVERLOAD | SUPPLY_OUT_OF_RANGE | REGULATOR_UV | OVERHEAT;

  // Removal clears presence at once; insertion must hold for the debounce time
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      present_reg <= 1'b0;
      db_cnt_reg  <= '0;
    end else if (CLK_EN) begin
      if (!card_seen) begin
        present_reg <= 1'b0;
        db_cnt_reg  <= '0;
      end else if (!present_reg) begin
        if (db_cnt_reg == DB_CNT_W'(DEBOUNCE_CYC - 1)) begin
          present_reg <= 1'b1;
        end else begin
          db_cnt_reg <= db_cnt_reg + 1'b1;
        end
      end
    end
  end

  // Fault keeps presence low until the host asks for a new session
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      fault_hold_reg <= 1'b0;
      cmd_prev_reg   <= 1'b1;
    end else if (CLK_EN) begin
      cmd_prev_reg <= SESSION_CMD_N;
      if (fault_any) begin
        fault_hold_reg <= 1'b1;
      end else if (cmd_prev_reg && !SESSION_CMD_N) begin
        fault_hold_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Any of these ends a session; command high is the host's normal close
  assign abort = SESSION_CMD_N | ~card_seen | HOST_SUPPLY_LOW_DETECT | fault_any;
  assign session_up = (state_reg == ST_ACT_SUPPLY) || (state_reg == ST_ACT_LINES)
                   || (state_reg == ST_ACTIVE);

  // Next state; power-up runs only on a fresh falling command edge
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_prev_reg && !SESSION_CMD_N && present_reg && !fault_hold_reg
            && !HOST_SUPPLY_LOW_DETECT && !fault_any) begin
          state_next = ST_ACT_SUPPLY;
        end
      end
      ST_ACT_SUPPLY: begin
        if (abort) state_next = ST_DEACT_RESET;
        else if (seq_cnt_reg == SEQ_CNT_W'(ACT_STEP_CYCLES - 1)) state_next = ST_ACT_LINES;
      end
      ST_ACT_LINES: begin
        if (abort) state_next = ST_DEACT_RESET;
        else if (seq_cnt_reg == SEQ_CNT_W'(ACT_STEP_CYCLES - 1)) state_next = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (abort) state_next = ST_DEACT_RESET;
      end
      ST_DEACT_RESET: begin
        if (seq_cnt_reg == SEQ_CNT_W'(DEACT_CLK_CYCLES - 1)) begin
          state_next = ST_DEACT_CLOCK;
        end
      end
      ST_DEACT_CLOCK:  state_next = ST_DEACT_LINES;
      ST_DEACT_LINES:  state_next = ST_DEACT_SUPPLY;
      default:         state_next = ST_IDLE;
    endcase
  end

  // State and step timer; the timer restarts on each state change
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_reg   <= ST_IDLE;
      seq_cnt_reg <= '0;
    end else if (CLK_EN) begin
      state_reg <= state_next;
      if (state_next != state_reg) seq_cnt_reg <= '0;
      else seq_cnt_reg <= seq_cnt_reg + 1'b1;
    end
  end

  // Contact drive registered from next state, so each step lands with its state
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      reset_out_reg <= 1'b0;
      clock_out_reg <= 1'b0;
      supply_reg    <= 1'b0;
      lines_low_reg <= 1'b1;
      clk_live_reg  <= 1'b0;
    end else if (CLK_EN) begin
      reset_out_reg <= (state_next == ST_ACTIVE) & HOST_RESET_IN;
      clk_live_reg  <= (state_next == ST_ACTIVE) | ((state_next == ST_DEACT_RESET) & clk_live_reg);
      // Gating is not glitch-free: a stop mid-pulse can shorten the last half period
      clock_out_reg <= clk_run_reg & div_clk_reg & ((state_next == ST_ACTIVE)
                     | ((state_next == ST_DEACT_RESET) & clk_live_reg));
      lines_low_reg <= !((state_next == ST_ACT_LINES) || (state_next == ST_ACTIVE)
                     || (state_next == ST_DEACT_RESET) || (state_next == ST_DEACT_CLOCK));
      supply_reg    <= (state_next != ST_IDLE) && (state_next != ST_DEACT_SUPPLY);
    end
  end

  assign CARD_RESET_OUT     = reset_out_reg;
  assign CARD_CLOCK_OUT     = clock_out_reg;
  assign CARD_SUPPLY_OUT    = supply_reg;
  assign CARD_DATA_LINE_O   = 1'b0;
  assign CARD_DATA_LINE_OE  = lines_low_reg;
  assign CARD_AUX_LINE_A_O  = 1'b0;
  assign CARD_AUX_LINE_A_OE = lines_low_reg;
  assign CARD_AUX_LINE_B_O  = 1'b0;
  assign CARD_AUX_LINE_B_OE = lines_low_reg;
  assign PRESENCE_OUT       = present_reg & ~fault_hold_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and interrupt

  assign events[EV_INSERT]     = card_seen & ~present_reg & (db_cnt_reg == DB_CNT_W'(DEBOUNCE_CYC - 1));
  assign events[EV_REMOVE]     = present_reg & ~card_seen;
  assign events[EV_FAULT]      = fault_any;
  assign events[EV_HOST_LOW]   = HOST_SUPPLY_LOW_DETECT & session_up;
  assign events[EV_DEACT_DONE] = state_reg == ST_DEACT_SUPPLY;

  // Write-one-to-clear; a new event in the clear cycle wins
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      status_reg  <= '0;
      mask_reg    <= MASK_RST;
      clk_run_reg <= CTRL_CLK_RUN_RST;
    end else if (CLK_EN) begin
      if (REG_WR && REG_ADDR == OFS_STATUS) status_reg <= (status_reg & ~REG_WDATA[EV_W-1:0]) | events;
      else status_reg <= status_reg | events;
      if (REG_WR && REG_ADDR == OFS_MASK) mask_reg <= REG_WDATA[EV_W-1:0];
      if (REG_WR && REG_ADDR == OFS_CONTROL) clk_run_reg <= REG_WDATA[CTRL_CLK_RUN_BIT];
    end
  end

  // Read data one cycle after the strobe, zero elsewhere and for unmapped offsets
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rdata_reg <= '0;
    end else if (CLK_EN) begin
      rdata_reg <= '0;
      if (REG_RD) begin
        if (REG_ADDR == OFS_CONTROL) rdata_reg <= {7'h00, clk_run_reg};
        else if (REG_ADDR == OFS_STATUS) rdata_reg <= {3'h0, status_reg};
        else if (REG_ADDR == OFS_MASK) rdata_reg <= {3'h0, mask_reg};
        else if (REG_ADDR == OFS_STATE) rdata_reg <= {2'h0, fault_hold_reg, present_reg, 1'b0, state_reg};
      end
    end
  end

  assign REG_RDATA = rdata_reg;
  assign IRQ       = |(status_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence enter_deact_s;
    state_reg != ST_DEACT_RESET ##1 state_reg == ST_DEACT_RESET;
  endsequence
  sequence close_steps_s;
    state_reg == ST_DEACT_CLOCK ##1 state_reg == ST_DEACT_LINES ##1 state_reg == ST_DEACT_SUPPLY;
  endsequence

  half_period_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    // A ratio change can leave the count above the new half length until the next edge
    ($changed(div_clk_reg) && $past(ratio) != RATIO_DIV1 && $stable(ratio)
      && $past(ratio, 2) == $past(ratio) && $past(ratio, 3) == $past(ratio))
      |-> ($past(hclk_rise) && $past(div_cnt_reg) == half_len))
    else $error("Divider toggled off its half period");
  clock_gate_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    clock_out_reg |-> (state_reg == ST_ACTIVE || state_reg == ST_DEACT_RESET))
    else $error("Card clock outside the active window");
  reset_first_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    enter_deact_s |-> !reset_out_reg)
    else $error("Card reset not low at power-down start");
  clock_delay_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    (state_reg == ST_DEACT_CLOCK) |->
      ($past(state_reg) == ST_DEACT_RESET && $past(seq_cnt_reg) == SEQ_CNT_W'(DEACT_CLK_CYCLES - 1)
       && !clock_out_reg))
    else $error("Card clock stop not at the 12 us mark");
  line_order_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    close_steps_s |-> (lines_low_reg && !clock_out_reg && supply_reg == 1'b0))
    else $error("Power-down steps out of order");
  supply_last_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    $fell(supply_reg) |-> ($past(lines_low_reg) && !$past(clock_out_reg) && !reset_out_reg))
    else $error("Supply off before lines were low");
  absent_low_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    !card_seen |=> !PRESENCE_OUT)
    else $error("Presence high with no card");
  debounce_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    $rose(present_reg) |-> ($past(db_cnt_reg) == DB_CNT_W'(DEBOUNCE_CYC - 1) && $past(card_seen)))
    else $error("Presence rose before the debounce ended");
  removal_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    (state_reg == ST_ACTIVE && !card_seen) |=> (state_reg == ST_DEACT_RESET && !PRESENCE_OUT))
    else $error("Removal did not start power-down");
  host_low_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    (session_up && HOST_SUPPLY_LOW_DETECT) |=> state_reg == ST_DEACT_RESET)
    else $error("Host undervoltage ignored");
  fault_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST || !CLK_EN)
    (session_up && fault_any) |=> (state_reg == ST_DEACT_RESET && !PRESENCE_OUT))
    else $error("Fault did not force power-down");

endmodule
`default_nettype wire

// [card_host_model.sv]
// Far side model: host clock and session pin, card switch, pulled-up data line.
// Assumes the bench drives card_in and nc_switch and calls the session tasks.
`timescale 1ns/100ps
`default_nettype none
module card_host_model (
  // Clock and device line enable
  input  wire logic sys_clk,
  input  wire logic data_oe,
  // Levels seen by the device
  output logic      host_clk,
  output logic      session_n,
  output logic      detect_raw,
  output logic      data_wire,
  // Scenario controls
  input  wire logic card_in,
  input  wire logic nc_switch
);
  // Free running host clock at half the system rate
  initial host_clk = 1'b0;
  always @(posedge sys_clk) host_clk <= ~host_clk;
  // Pin idles high while no session is open
  initial session_n = 1'b1;
  // Switch level for either contact type
  assign detect_raw = card_in ^ nc_switch;
  // Pull-up wins unless the device pulls low
  assign data_wire = data_oe ? 1'b0 : 1'b1;
  // Open with a falling edge
  task automatic open_s();
    @(posedge sys_clk) session_n <= 1'b0;
  endtask
  // End the session with a high level
  task automatic close_s();
    @(posedge sys_clk) session_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [card_interface_sequencer_tb.sv]
// Self-checking bench for the card interface sequencer.
// Assumes a short debounce parameter; all inputs move by NBA, at the clock edge or 1 ns after it.
`timescale 1ns/100ps
`default_nettype none
module card_interface_sequencer_tb;
  import card_seq_pkg::*;
  localparam int DB = 20;
  typedef struct { logic [1:0] sel; int half; } row_t;
  logic       clk = 1'b0, rst = 1'b1, hrst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic       card_in = 1'b0, nc = 1'b0, ilim = 1'b0;
  logic [1:0] sel = RATIO_DIV8;
  logic [4:0] flt = 5'h00;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       hclk, sess_n, raw, dwire, pres, rst_o, card_clock_out, sup, irq;
  logic       d_oe, a_oe, b_oe;
  logic [7:0] rdata;
  int         n_errors = 0, check_count = 0, hi_seen = 0, n, hi, lo;
  // Expected card clock half periods; host clock toggles every cycle
  row_t       rows[4] = '{'{RATIO_DIV8, 8}, '{RATIO_DIV4, 4}, '{RATIO_DIV1, 1}, '{RATIO_DIV2, 2}};

  always #12.5 clk = ~clk;

  card_host_model hm (
    .sys_clk(clk), .data_oe(d_oe), .host_clk(hclk), .session_n(sess_n),
    .detect_raw(raw), .data_wire(dwire), .card_in(card_in), .nc_switch(nc));

  card_interface_sequencer #(.DEBOUNCE_CYC(DB)) u_dut (
    .SYS_CLK(clk), .SYS_RST(rst), .CLK_EN(1'b1), .HOST_CLOCK_IN(hclk),
    .RATIO_SEL_HI(sel[1]), .RATIO_SEL_LO(sel[0]), .SESSION_CMD_N(sess_n),
    .HOST_RESET_IN(hrst), .PRESENCE_OUT(pres), .CARD_DETECT_RAW(raw), .DETECT_NC(nc),
    .HOST_SUPPLY_LOW_DETECT(flt[0]), .SUPPLY_OVERLOAD(flt[1]),
    .SUPPLY_OUT_OF_RANGE(flt[2]), .REGULATOR_UV(flt[3]), .OVERHEAT(flt[4]),
    .PIN_CURRENT_LIMIT(ilim), .CARD_RESET_OUT(rst_o), .CARD_CLOCK_OUT(card_clock_out),
    .CARD_SUPPLY_OUT(sup), .CARD_DATA_LINE_O(), .CARD_DATA_LINE_OE(d_oe),
    .CARD_AUX_LINE_A_O(), .CARD_AUX_LINE_A_OE(a_oe), .CARD_AUX_LINE_B_O(),
    .CARD_AUX_LINE_B_OE(b_oe), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .IRQ(irq));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Sample settled values just after an edge
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: pick = rst_o;
      1: pick = sup;
      2: pick = d_oe;
      default: pick = card_clock_out;
    endcase
  endfunction
  // Bounded wait; a hang counts as a mismatch and ends the run
  task automatic wait_lvl(input int w, input logic lvl, output int k);
    k = 0;
    while (pick(w) !== lvl) begin
      hi_seen += card_clock_out;
      cyc(1);
      k++;
      if (k > 2000) begin
        check(pick(w), lvl);
        close_out();
      end
    end
  endtask
  // Register port: one-cycle strobes, read data in the next cycle only
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, e);
  endtask
  // Session open; the card must see no clock before activation ends
  task automatic open_wait();
    int k;
    hi_seen = 0;
    hm.open_s();
    wait_lvl(0, 1'b1, k);
    check(hi_seen, 0);
    check({sup, d_oe}, 2'b10);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(16);
    rst <= 1'b0;
    hrst <= 1'b1;
    cyc(1);
    check({sup, pres, irq, rdata, d_oe}, 12'h001);
    rd_chk(OFS_CONTROL, 8'h01);
    rd_chk(OFS_MASK, 8'h00);
    $display("done: reset");
    // Presence for both switch types; debounce on insertion only
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      nc <= p[0];
      card_in <= 1'b0;
      cyc(DB + 5);
      check(pres, 0);
      card_in <= 1'b1;
      cyc(DB / 2);
      check(pres, 0);
      cyc(DB);
      check(pres, 1);
    end
    $display("done: presence");
    open_wait();
    // Table of ratios, measured on the low and the high half period of the card clock
    foreach (rows[i]) begin
      @(posedge clk);
      sel <= rows[i].sel;
      cyc(20);
      wait_lvl(3, 1'b1, n);
      wait_lvl(3, 1'b0, n);
      wait_lvl(3, 1'b1, lo);
      wait_lvl(3, 1'b0, hi);
      check(hi, rows[i].half);
      check(lo, rows[i].half);
    end
    $display("done: ratios");
    // Host gating of the running clock
    wr_reg(OFS_CONTROL, 8'h00);
    n = 0;
    repeat (30) begin
      cyc(1);
      n += card_clock_out;
    end
    check(n, 0);
    wr_reg(OFS_CONTROL, 8'h01);
    // Current limit trip must stay invisible
    wr_reg(OFS_STATUS, 8'h1F);
    ilim <= 1'b1;
    cyc(20);
    ilim <= 1'b0;
    check({rst_o, pres, irq}, 3'b110);
    rd_chk(OFS_STATUS, 8'h00);
    $display("done: gating");
    // Normal power-down, step by step
    hm.close_s();
    wait_lvl(0, 1'b0, n);
    check({sup, d_oe, a_oe, b_oe}, 4'h8);
    wait_lvl(2, 1'b1, n);
    check(n, DEACT_CLK_CYCLES + 1);
    check({card_clock_out, a_oe, b_oe, dwire}, 4'h6);
    check(sup, 1);
    cyc(1);
    check(sup, 0);
    // Sticky status, mask and level interrupt
    rd_chk(OFS_STATUS, 8'h10);
    check(irq, 0);
    wr_reg(OFS_MASK, 8'h10);
    cyc(1);
    check(irq, 1);
    wr_reg(OFS_STATUS, 8'h10);
    cyc(1);
    check(irq, 0);
    rd_chk(4'h2, 8'h00);
    rd_chk(OFS_MASK, 8'h10);
    $display("done: power-down");
    // Removal in session: no debounce on the way out
    open_wait();
    card_in <= 1'b0;
    cyc(1);
    check(pres, 0);
    wait_lvl(0, 1'b0, n);
    check(n < 3, 1);
    wait_lvl(1, 1'b0, n);
    hm.close_s();
    card_in <= 1'b1;
    cyc(DB + 5);
    $display("done: removal");
    // Host supply low, then each fault source
    for (int i = 0; i < 5; i++) begin
      wr_reg(OFS_STATUS, 8'h1F);
      open_wait();
      flt[i] <= 1'b1;
      wait_lvl(0, 1'b0, n);
      check(n < 4, 1);
      wait_lvl(1, 1'b0, n);
      if (i > 0) begin
        check(pres, 0);
      end
      rd_chk(OFS_STATUS, (i == 0) ? 8'h18 : 8'h14);
      flt[i] <= 1'b0;
      hm.close_s();
      cyc(3);
      // Held fault needs one refused open edge to clear
      if (i > 0) begin
        hm.open_s();
        cyc(3);
        hm.close_s();
        cyc(3);
      end
    end
    $display("done: faults");
    close_out();
  end
endmodule
`default_nettype wire
